// >>> pkg/dol_pkg.sv
// Purpose: Shared constants and types for the deserializer output control
// Assumes: One serial bit per sys_clk cycle, 12-bit embedded-clock frames
// Notes:   Register offsets are byte addresses on the plain register port

package dol_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int FRAME_BITS       = 12;
  localparam int WORD_BITS        = 10;
  localparam int LOCK_LOSS_FRAMES = 4;
  localparam int LOCK_GAIN_FRAMES = 4;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATE      = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h0C;
  localparam logic [7:0]  ADDR_LAST_WORD  = 8'h10;
  localparam logic [31:0] RDATA_NONE      = 32'h0000_0000;

  // CTRL fields
  localparam int CTRL_RELOCK = 0;

  // STATE fields
  localparam int STATE_LOCKED = 0;
  localparam int STATE_ENABLE = 1;
  localparam int STATE_POWER  = 2;
  localparam int STATE_EDGE   = 3;

  // Interrupt bits
  localparam int          IRQ_BITS   = 3;
  localparam logic [2:0]  MASK_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ctrl;
    logic [7:0] data;
  } dol_word_t;

  typedef struct packed {
    logic frame_err;
    logic lock_lost;
    logic lock_gained;
  } dol_events_t;

  typedef enum logic [1:0] {
    DOL_HUNT   = 2'b01,
    DOL_LOCKED = 2'b10
  } dol_state_t;

endpackage : dol_pkg

// >>> rtl/dol_deser_ctrl.sv
// Purpose: Lock detection, recovered strobe and output enables of a
//          10-bit embedded-clock deserializer
// Assumes: serial_in_pos/neg synchronous to sys_clk, one bit per cycle
// Notes:   Frame is start 1, ten data bits MSB first, stop 0
//
// Decided for this implementation: the placing of the registers and strobed register access.

`timescale 1ns/1ns

module dol_deser_ctrl #(
  parameter int FRAME_BITS       = dol_pkg::FRAME_BITS,
  parameter int LOCK_LOSS_FRAMES = dol_pkg::LOCK_LOSS_FRAMES,
  parameter int LOCK_GAIN_FRAMES = dol_pkg::LOCK_GAIN_FRAMES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  input  wire logic                         serial_in_pos,
  input  wire logic                         serial_in_neg,
  input  wire logic                         power_down_n,
  input  wire logic                         out_enable,
  input  wire logic                         strobe_rising,
  input  wire logic [dol_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [dol_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [dol_pkg::DATA_W-1:0]   reg_rdata,
  output logic                              irq,
  output dol_pkg::dol_word_t                parallel_word_out,
  output logic                              parallel_word_oe,
  output logic                              recovered_clock,
  output logic                              recovered_clock_oe,
  output logic                              lock_n,
  output logic                              lock_oe
);

  // ----------------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------------
  localparam int CNT_W = $clog2(FRAME_BITS);
  localparam int GOOD_W = $clog2(LOCK_GAIN_FRAMES + 1);
  localparam int BAD_W = $clog2(LOCK_LOSS_FRAMES + 1);
  localparam logic [CNT_W-1:0] BIT_FIRST = '0;
  localparam logic [CNT_W-1:0] BIT_SLIP = CNT_W'(1);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(FRAME_BITS - 1);
  localparam logic [CNT_W-1:0] BIT_HALF = CNT_W'(FRAME_BITS / 2);
  localparam logic [GOOD_W-1:0] GOOD_DONE = GOOD_W'(LOCK_GAIN_FRAMES - 1);
  localparam logic [BAD_W-1:0] BAD_DONE = BAD_W'(LOCK_LOSS_FRAMES - 1);
  localparam logic [GOOD_W-1:0] GOOD_ONE = GOOD_W'(1);
  localparam logic [BAD_W-1:0] BAD_ONE = BAD_W'(1);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  dol_pkg::dol_state_t              state;
  dol_pkg::dol_state_t              next_state;
  dol_pkg::dol_word_t               captured;
  dol_pkg::dol_events_t             events;
  logic [FRAME_BITS-1:0]            frame_sr;
  logic [FRAME_BITS-1:0]            next_sr;
  logic [CNT_W-1:0]                 bit_cnt;
  logic [GOOD_W-1:0]                good_cnt;
  logic [BAD_W-1:0]                 bad_cnt;
  logic                             bit_err;
  logic                             serial_bit;
  logic                             serial_bad;
  logic                             frame_end;
  logic                             frame_ok;
  logic                             locked;
  logic                             relock_req;
  logic                             strobe_now;
  logic [dol_pkg::IRQ_BITS-1:0]     irq_status;
  logic [dol_pkg::IRQ_BITS-1:0]     irq_mask;
  logic [dol_pkg::IRQ_BITS-1:0]     irq_clear;
  logic [dol_pkg::DATA_W-1:0]       next_rdata;

  // ----------------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------------
  // Equal legs mean no valid differential level; such a bit spoils its frame
  assign serial_bit = serial_in_pos;
  assign serial_bad = (serial_in_pos == serial_in_neg);
  assign next_sr = {frame_sr[FRAME_BITS-2:0], serial_bit};
  assign frame_end = (bit_cnt == BIT_LAST);
  // Embedded clock edge: start bit high, stop bit low
  assign frame_ok = next_sr[FRAME_BITS-1] & ~next_sr[0] & ~bit_err
                    & ~serial_bad;
  assign locked = (state == dol_pkg::DOL_LOCKED);
  assign relock_req = reg_wr & (reg_addr == dol_pkg::ADDR_CTRL)
                      & reg_wdata[dol_pkg::CTRL_RELOCK];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frame_sr <= '0;
    end else if (!power_down_n) begin
      frame_sr <= '0;
    end else begin
      frame_sr <= next_sr;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_err <= 1'b0;
    end else if (!power_down_n || frame_end) begin
      bit_err <= 1'b0;
    end else if (serial_bad) begin
      bit_err <= 1'b1;
    end
  end

  // Slipping one bit per frame failed while hunting walks the window onto the
  // embedded edge; cheaper than a parallel search over all phases
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= BIT_FIRST;
    end else if (!power_down_n) begin
      bit_cnt <= BIT_FIRST;
    end else if (frame_end) begin
      if (!locked && !frame_ok) begin
        bit_cnt <= BIT_SLIP;
      end else begin
        bit_cnt <= BIT_FIRST;
      end
    end else begin
      bit_cnt <= bit_cnt + BIT_SLIP;
    end
  end

  // ----------------------------------------------------------------------
  // Lock state machine
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      dol_pkg::DOL_HUNT: begin
        if (frame_end && frame_ok && good_cnt == GOOD_DONE) begin
          next_state = dol_pkg::DOL_LOCKED;
        end
      end
      dol_pkg::DOL_LOCKED: begin
        if (relock_req) begin
          next_state = dol_pkg::DOL_HUNT;
        end else if (frame_end && !frame_ok && bad_cnt == BAD_DONE) begin
          next_state = dol_pkg::DOL_HUNT;
        end
      end
      default: begin
        next_state = dol_pkg::DOL_HUNT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= dol_pkg::DOL_HUNT;
    end else if (!power_down_n) begin
      state <= dol_pkg::DOL_HUNT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      good_cnt <= '0;
    end else if (!power_down_n || locked) begin
      good_cnt <= '0;
    end else if (frame_end) begin
      if (frame_ok) begin
        good_cnt <= good_cnt + GOOD_ONE;
      end else begin
        good_cnt <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bad_cnt <= '0;
    end else if (!power_down_n || !locked) begin
      bad_cnt <= '0;
    end else if (frame_end) begin
      if (frame_ok) begin
        bad_cnt <= '0;
      end else begin
        bad_cnt <= bad_cnt + BAD_ONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Word capture and strobe
  // ----------------------------------------------------------------------
  // Words arriving while loss is still being confirmed are passed on;
  // up to three of them ahead of lock_n rising may be corrupt
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      captured <= '0;
    end else if (frame_end && locked) begin
      captured <= next_sr[FRAME_BITS-2:1];
    end
  end

  // Data changes half a word away from the selected strobe edge
  assign strobe_now = strobe_rising ? (bit_cnt == BIT_HALF)
                                    : (bit_cnt == BIT_FIRST);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      parallel_word_out <= '0;
    end else if (locked && strobe_now) begin
      parallel_word_out <= captured;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      recovered_clock <= 1'b0;
    end else begin
      recovered_clock <= locked & (bit_cnt < BIT_HALF);
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  assign lock_n = ~locked;
  assign lock_oe = power_down_n;
  assign parallel_word_oe = power_down_n & out_enable & locked;
  assign recovered_clock_oe = power_down_n & out_enable & locked;

  // ----------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------
  // Power down overrides the lock decision, so no gain may be flagged then
  assign events.lock_gained = (state == dol_pkg::DOL_HUNT)
                              & (next_state == dol_pkg::DOL_LOCKED)
                              & power_down_n;
  assign events.lock_lost = locked & (next_state == dol_pkg::DOL_HUNT)
                            & power_down_n;
  assign events.frame_err = frame_end & locked & ~frame_ok & power_down_n;
  assign irq_clear = (reg_wr && reg_addr == dol_pkg::ADDR_IRQ_STATUS)
                     ? reg_wdata[dol_pkg::IRQ_BITS-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | events;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= dol_pkg::MASK_RESET;
    end else if (reg_wr && reg_addr == dol_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= reg_wdata[dol_pkg::IRQ_BITS-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = dol_pkg::RDATA_NONE;
    if (reg_addr == dol_pkg::ADDR_STATE) begin
      next_rdata[dol_pkg::STATE_LOCKED] = locked;
      next_rdata[dol_pkg::STATE_ENABLE] = out_enable;
      next_rdata[dol_pkg::STATE_POWER] = power_down_n;
      next_rdata[dol_pkg::STATE_EDGE] = strobe_rising;
    end else if (reg_addr == dol_pkg::ADDR_IRQ_STATUS) begin
      next_rdata[dol_pkg::IRQ_BITS-1:0] = irq_status;
    end else if (reg_addr == dol_pkg::ADDR_IRQ_MASK) begin
      next_rdata[dol_pkg::IRQ_BITS-1:0] = irq_mask;
    end else if (reg_addr == dol_pkg::ADDR_LAST_WORD) begin
      next_rdata[dol_pkg::WORD_BITS-1:0] = captured;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= dol_pkg::RDATA_NONE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= dol_pkg::RDATA_NONE;
    end
  end

endmodule : dol_deser_ctrl

// >>> tb/dol_ser_model.sv
// Purpose: Behavioural serializer at the far end of the serial link
// Assumes: Frame is start 1, ten bits MSB first, stop 0
// Notes:   tx_bad makes both legs equal for a whole frame
`timescale 1ns/1ns
module dol_ser_model (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               pattern_request_a,
  input  wire dol_pkg::dol_word_t tx_word,
  input  wire logic               tx_bad,
  output logic                    serial_in_pos,
  output logic                    serial_in_neg,
  output logic                    frame_done
);
  // --------------------------------------------------------------------
  // Framing
  // --------------------------------------------------------------------
  localparam logic [9:0] SYNC_WORD = 10'h3E0;
  logic [3:0] bit_cnt;
  logic [9:0] cur;
  logic       cur_bad;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= 4'h0;
      cur     <= SYNC_WORD;
      cur_bad <= 1'b0;
    end else if (bit_cnt == 4'hB) begin
      bit_cnt <= 4'h0;
      cur     <= pattern_request_a ? SYNC_WORD : tx_word;
      cur_bad <= tx_bad;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Both legs always driven, so no stale level hides a fault
  assign serial_in_pos = (bit_cnt == 4'h0) ? 1'b1 :
                         (bit_cnt == 4'hB) ? 1'b0 : cur[4'hA - bit_cnt];
  assign serial_in_neg = cur_bad ? serial_in_pos : ~serial_in_pos;
  assign frame_done    = (bit_cnt == 4'hB);
endmodule : dol_ser_model

// >>> tb/dol_ctrl_asserts.sv
// Purpose: Port checks of lock indicator, strobe and enables
// Assumes: Bound to every dol_deser_ctrl
// Notes:   Pads are not modelled, only enables
`timescale 1ns/1ns
module dol_ctrl_asserts (
  input wire logic                       sys_clk,
  input wire logic                       resetn,
  input wire logic                       power_down_n,
  input wire logic                       out_enable,
  input wire logic                       reg_rd,
  input wire logic [dol_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       parallel_word_oe,
  input wire logic                       recovered_clock,
  input wire logic                       recovered_clock_oe,
  input wire logic                       lock_n,
  input wire logic                       lock_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  pd_float_a: assert property (!power_down_n |->
    !parallel_word_oe && !recovered_clock_oe && !lock_oe)
    else $error("outputs driven in power down");
  lock_pin_a: assert property (lock_oe == power_down_n)
    else $error("lock enable wrong");
  en_float_a: assert property (!out_enable |->
    !parallel_word_oe && !recovered_clock_oe)
    else $error("outputs driven while disabled");
  unlock_float_a: assert property (lock_n |->
    !parallel_word_oe && !recovered_clock_oe)
    else $error("outputs driven while unlocked");
  lock_active_a: assert property (!lock_n && out_enable && power_down_n
    |-> parallel_word_oe && recovered_clock_oe)
    else $error("outputs floating while locked");
  clk_still_a: assert property (lock_n [*2] |-> !recovered_clock)
    else $error("strobe runs while unlocked");
  clk_rate_a: assert property ($rose(recovered_clock) |->
    (recovered_clock [*6] ##1 !recovered_clock) or (##[1:6] lock_n))
    else $error("strobe high phase not six cycles");
  rdata_idle_a: assert property (!$past(reg_rd) |->
    reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule : dol_ctrl_asserts

bind dol_deser_ctrl dol_ctrl_asserts u_dol_ctrl_asserts (
  .sys_clk(sys_clk), .resetn(resetn), .power_down_n(power_down_n),
  .out_enable(out_enable), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .parallel_word_oe(parallel_word_oe), .recovered_clock(recovered_clock),
  .recovered_clock_oe(recovered_clock_oe), .lock_n(lock_n),
  .lock_oe(lock_oe));

// >>> tb/tb_top.sv
// Purpose: Directed bench of lock, enables, strobe edge and registers
// Assumes: Serializer model supplies frames from reset release
// Notes:   Sync pattern requested by feeding lock_n back
`timescale 1ns/1ns
module tb_top;
  logic               sys_clk, resetn, serial_in_pos, serial_in_neg;
  logic               power_down_n, out_enable, strobe_rising;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata, rd;
  logic               reg_wr, reg_rd, irq, parallel_word_oe, lock_n;
  logic               recovered_clock, recovered_clock_oe, lock_oe;
  dol_pkg::dol_word_t parallel_word_out, tx_word;
  logic               tx_bad, frame_done, rc_rise, rc_fall;
  int                 fail_count, checks;

  dol_deser_ctrl u_dol_deser_ctrl (.sys_clk(sys_clk), .resetn(resetn),
    .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg),
    .power_down_n(power_down_n), .out_enable(out_enable),
    .strobe_rising(strobe_rising), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq),
    .parallel_word_out(parallel_word_out),
    .parallel_word_oe(parallel_word_oe), .recovered_clock(recovered_clock),
    .recovered_clock_oe(recovered_clock_oe), .lock_n(lock_n),
    .lock_oe(lock_oe));
  dol_ser_model u_dol_ser_model (.sys_clk(sys_clk), .resetn(resetn),
    .pattern_request_a(lock_n), .tx_word(tx_word), .tx_bad(tx_bad),
    .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg),
    .frame_done(frame_done));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e,
                         input string m);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk_val
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  task automatic wait_lock(input logic e);
    int n;
    n = 0;
    while (lock_n !== e && n < 800) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk_bit(lock_n, e, "lock state");
  endtask : wait_lock
  task automatic frames(input int n);
    repeat (n) begin
      do @(posedge sys_clk); while (frame_done !== 1'b1);
    end
    #1;
  endtask : frames
  // Strobe level seen right after the word changes
  task automatic probe(input logic [9:0] w, output logic r);
    int n;
    n = 0;
    @(posedge sys_clk) tx_word <= w;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (parallel_word_out !== w && n < 60);
    chk_val(32'(parallel_word_out), 32'(w), "probe word");
    r = recovered_clock;
  endtask : probe
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end
  initial begin
    {resetn, reg_wr, reg_rd, tx_bad} = 4'h0;
    {power_down_n, out_enable, strobe_rising} = 3'h7;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    tx_word = 10'h2A5;
    fail_count = 0;
    checks = 0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    #1 chk_bit(lock_n, 1'b1, "unlocked");
    chk_bit(parallel_word_oe, 1'b0, "float unlocked");
    wait_lock(1'b0);
    reg_write(dol_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
    reg_read(dol_pkg::ADDR_IRQ_STATUS, rd);
    chk_val(rd, 32'h0000_0001, "gain status");
    chk_bit(irq, 1'b1, "irq set");
    reg_write(dol_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    reg_read(dol_pkg::ADDR_IRQ_STATUS, rd);
    chk_val(rd, 32'h0000_0000, "status cleared");
    chk_bit(irq, 1'b0, "irq clear");
    reg_read(dol_pkg::ADDR_STATE, rd);
    chk_val(rd, 32'h0000_000F, "state");
    reg_read(8'h20, rd);
    chk_val(rd, 32'h0000_0000, "unmapped");
    frames(3);
    chk_val(32'(parallel_word_out), 32'h0000_02A5, "word");
    reg_read(dol_pkg::ADDR_LAST_WORD, rd);
    chk_val(rd, 32'h0000_02A5, "last word");
    probe(10'h15A, rc_rise);
    @(posedge sys_clk) strobe_rising <= 1'b0;
    probe(10'h0C3, rc_fall);
    // Rising select: data moves on the falling strobe edge, and vice versa
    chk_bit(rc_rise, 1'b0, "strobe rising edge");
    chk_bit(rc_fall, 1'b1, "strobe falling edge");
    @(posedge sys_clk) out_enable <= 1'b0;
    #1 chk_bit(recovered_clock_oe, 1'b0, "disabled clock");
    chk_bit(lock_oe, 1'b1, "lock kept driven");
    chk_bit(lock_n, 1'b0, "lock tracks");
    @(posedge sys_clk) out_enable <= 1'b1;
    @(posedge sys_clk) tx_bad <= 1'b1;
    frames(4);
    repeat (2) @(posedge sys_clk);
    #1 chk_bit(lock_n, 1'b0, "three bad frames");
    frames(1);
    repeat (2) @(posedge sys_clk);
    #1 chk_bit(lock_n, 1'b1, "fourth bad frame");
    @(posedge sys_clk) tx_bad <= 1'b0;
    reg_read(dol_pkg::ADDR_IRQ_STATUS, rd);
    chk_val(rd, 32'h0000_0006, "loss status");
    wait_lock(1'b0);
    reg_write(dol_pkg::ADDR_CTRL, 32'h0000_0001);
    #1 chk_bit(lock_n, 1'b1, "relock request");
    wait_lock(1'b0);
    @(posedge sys_clk) power_down_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk_bit(lock_oe, 1'b0, "power down");
    @(posedge sys_clk) power_down_n <= 1'b1;
    #1 chk_bit(lock_n, 1'b1, "restart unlocked");
    chk_bit(recovered_clock_oe, 1'b0, "restart floating");
    wait_lock(1'b0);
    stop_test();
  end
endmodule : tb_top
